// *** mac_half_mul.sv ***
// signed 16x16 multiplier with independent halfword selection per operand
`timescale 1ns/1ps
module mac_half_mul (
  input wire logic [mac_pkg::WORD_W-1:0] firstWord,
  input wire logic [mac_pkg::WORD_W-1:0] secondWord,
  input wire logic firstTop,
  input wire logic secondTop,
  output logic signed [mac_pkg::WORD_W-1:0] product
);
  logic signed [mac_pkg::HALF_W-1:0] firstHalf;
  logic signed [mac_pkg::HALF_W-1:0] secondHalf;

  // unselected halves never reach the multiplier
  always_comb begin
    firstHalf = firstTop ? firstWord[mac_pkg::HALF_W +: mac_pkg::HALF_W]
                         : firstWord[0 +: mac_pkg::HALF_W];
    secondHalf = secondTop ? secondWord[mac_pkg::HALF_W +: mac_pkg::HALF_W]
                           : secondWord[0 +: mac_pkg::HALF_W];
    product = firstHalf * secondHalf;
  end
endmodule

// *** mac_host_model.sv ***
// bus master standing in for the core's decoder and register file
`timescale 1ns/1ps
module mac_host_model (
  input wire logic sys_clk,
  output logic [mac_pkg::ADDR_W-1:0] avsAddress,
  output logic avsRead,
  output logic avsWrite,
  output logic [mac_pkg::DATA_W-1:0] avsWriteData,
  output logic [mac_pkg::BE_W-1:0] avsByteEnable,
  input wire logic [mac_pkg::DATA_W-1:0] avsReadData,
  input wire logic avsWaitRequest
);
  initial begin
    avsAddress = 6'h00;
    avsRead = 1'h0;
    avsWrite = 1'h0;
    avsWriteData = 32'h0000_0000;
    avsByteEnable = 4'hF;
  end

  // operands go in as plain register values, so no stack pointer, program counter
  // or shared high/low destination is ever named
  // one idle edge before each raise keeps release and raise in separate steps
  task automatic xfer(input logic wr, input logic [mac_pkg::ADDR_W-1:0] addr,
      input logic [31:0] wdata, output logic [31:0] rdata, output bit ok);
    int n;
    ok = 1'b0;
    rdata = 32'h0000_0000;
    @(posedge sys_clk);
    avsAddress <= addr;
    avsWrite <= wr;
    avsRead <= !wr;
    avsWriteData <= wdata;
    for (n = 0; n < 50 && !ok; n++) begin
      @(posedge sys_clk);
      if (avsWaitRequest === 1'h0) begin
        ok = 1'b1;
        rdata = avsReadData;
      end
    end
    avsRead <= 1'h0;
    avsWrite <= 1'h0;
    avsWriteData <= ~wdata;
  endtask
endmodule

// *** mac_pkg.sv ***
// shared constants and types of the multiply-accumulate unit
package mac_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  localparam int BYTE_W = 8;
  localparam int HALF_W = 16;
  localparam int WORD_W = 32;
  localparam int LONG_W = 64;
  localparam int WH_PROD_W = 48;
  localparam int WH_SHIFT = 16;

  // byte addresses of the software registers
  localparam logic [ADDR_W-1:0] OFS_FIRST = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_SECOND = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_ACC = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_DEST_LO = 6'h0C;
  localparam logic [ADDR_W-1:0] OFS_DEST_HI = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_RESULT = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 6'h1C;
  localparam logic [ADDR_W-1:0] OFS_FLAGS = 6'h20;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 6'h24;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 6'h28;

  // field positions
  localparam int CTRL_W = 7;
  localparam int CTRL_GO_BIT = 7;
  localparam int STAT_BUSY_BIT = 0;
  localparam int FLAGS_W = 5;
  localparam int FLAGS_LSB = 27;
  localparam int FLAG_Q = 0;
  localparam int NZCV_LSB = 1;
  localparam int IRQ_W = 2;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_SAT = 1;

  // reset values
  localparam logic [DATA_W-1:0] WORD_RST = 32'h0000_0000;
  localparam logic [LONG_W-1:0] LONG_RST = 64'h0000_0000_0000_0000;
  localparam logic [FLAGS_W-1:0] FLAGS_RST = 5'h00;
  localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;

  typedef enum logic [3:0] {
    OP_UL_MUL, OP_UL_MUL_ADD_ADD, OP_UL_MUL_ACC, OP_HALF_ACC, OP_WORD_HALF_ACC,
    OP_DUAL_ACC, OP_LONG_ACC, OP_LONG_HALF_ACC, OP_LONG_DUAL_ACC
  } mac_op_t;
  localparam logic [3:0] OP_LAST = 4'h8;

  typedef struct packed {
    logic exchange;
    logic selSecondTop;
    logic selFirstTop;
    mac_op_t op;
  } mac_ctrl_t;
  localparam mac_ctrl_t CTRL_RST = '{exchange: 1'b0, selSecondTop: 1'b0, selFirstTop: 1'b0,
                                     op: OP_UL_MUL};

  typedef enum logic [1:0] {ST_IDLE, ST_MUL, ST_ACC} mac_stage_t;
endpackage

// *** mac_unit.sv ***
// multiply-accumulate unit with Avalon-MM register access and interrupt
//
// Design decisions made here: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
module mac_unit (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [mac_pkg::ADDR_W-1:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [mac_pkg::DATA_W-1:0] avsWriteData,
  input wire logic [mac_pkg::BE_W-1:0] avsByteEnable,
  output logic [mac_pkg::DATA_W-1:0] avsReadData,
  output logic avsWaitRequest,
  output logic irq
);
  logic waitReq_r;
  logic [mac_pkg::DATA_W-1:0] readData_r;
  logic irq_r;
  logic [mac_pkg::WORD_W-1:0] firstOp_r;
  logic [mac_pkg::WORD_W-1:0] secondOp_r;
  logic [mac_pkg::WORD_W-1:0] accOp_r;
  logic [mac_pkg::WORD_W-1:0] destLo_r;
  logic [mac_pkg::WORD_W-1:0] destHi_r;
  logic [mac_pkg::WORD_W-1:0] result_r;
  mac_pkg::mac_ctrl_t ctrl_r;
  mac_pkg::mac_ctrl_t ctrlWr;
  mac_pkg::mac_stage_t stage_r;
  logic [mac_pkg::FLAGS_W-1:0] flags_r;
  logic [mac_pkg::IRQ_W-1:0] irqStat_r;
  logic [mac_pkg::IRQ_W-1:0] irqMask_r;
  logic [mac_pkg::LONG_W-1:0] prod_r;
  logic [mac_pkg::LONG_W-1:0] addend_r;
  logic [mac_pkg::LONG_W-1:0] prod_nxt;
  logic [mac_pkg::LONG_W-1:0] addend_nxt;
  logic [mac_pkg::LONG_W-1:0] sum;
  logic [mac_pkg::DATA_W-1:0] byteMask;
  logic [mac_pkg::DATA_W-1:0] wrMerged;
  logic wrEn;
  logic idle;
  logic launch;
  logic dualOp;
  logic wordAccOp;
  logic satOvf;
  logic finish;
  logic signed [mac_pkg::WORD_W-1:0] halfProd0;
  logic signed [mac_pkg::WORD_W-1:0] halfProd1;
  logic signed [mac_pkg::LONG_W-1:0] signedLong;
  logic signed [mac_pkg::WH_PROD_W-1:0] whProd;
  logic signed [mac_pkg::HALF_W-1:0] whHalf;

  function automatic logic [mac_pkg::HALF_W-1:0] halfPick(
    input logic [mac_pkg::WORD_W-1:0] w,
    input logic top
  );
    return top ? w[mac_pkg::HALF_W +: mac_pkg::HALF_W] : w[0 +: mac_pkg::HALF_W];
  endfunction

  function automatic logic [mac_pkg::LONG_W-1:0] sext32(input logic [mac_pkg::WORD_W-1:0] w);
    return {{mac_pkg::WORD_W{w[mac_pkg::WORD_W-1]}}, w};
  endfunction

  assign avsWaitRequest = waitReq_r;
  assign avsReadData = readData_r;
  assign irq = irq_r;

  // ---------------- bus slave ----------------
  // every access waits exactly one cycle; keeps read data a plain flop
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      waitReq_r <= 1'b1;
    end else if (!waitReq_r) begin
      waitReq_r <= 1'b1;
    end else if (avsRead || avsWrite) begin
      waitReq_r <= 1'b0;
    end
  end

  assign wrEn = avsWrite && !waitReq_r;
  assign idle = (stage_r == mac_pkg::ST_IDLE);

  always_comb begin
    byteMask = '0;
    for (int i = 0; i < mac_pkg::BE_W; i++) begin
      byteMask[i*mac_pkg::BYTE_W +: mac_pkg::BYTE_W] = {mac_pkg::BYTE_W{avsByteEnable[i]}};
    end
  end
  assign wrMerged = avsWriteData & byteMask;
  // control fields as written; the op code is range-checked before it is kept
  assign ctrlWr = mac_pkg::mac_ctrl_t'(avsWriteData[mac_pkg::CTRL_W-1:0]);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      readData_r <= mac_pkg::WORD_RST;
    end else if (waitReq_r && avsRead) begin
      case (avsAddress)
        mac_pkg::OFS_FIRST: readData_r <= firstOp_r;
        mac_pkg::OFS_SECOND: readData_r <= secondOp_r;
        mac_pkg::OFS_ACC: readData_r <= accOp_r;
        mac_pkg::OFS_DEST_LO: readData_r <= destLo_r;
        mac_pkg::OFS_DEST_HI: readData_r <= destHi_r;
        mac_pkg::OFS_RESULT: readData_r <= result_r;
        mac_pkg::OFS_CTRL: readData_r <= mac_pkg::DATA_W'(ctrl_r);
        mac_pkg::OFS_STATUS: readData_r <= mac_pkg::DATA_W'(!idle) << mac_pkg::STAT_BUSY_BIT;
        mac_pkg::OFS_FLAGS: readData_r <= mac_pkg::DATA_W'(flags_r) << mac_pkg::FLAGS_LSB;
        mac_pkg::OFS_IRQ_STAT: readData_r <= mac_pkg::DATA_W'(irqStat_r);
        mac_pkg::OFS_IRQ_MASK: readData_r <= mac_pkg::DATA_W'(irqMask_r);
        default: readData_r <= mac_pkg::WORD_RST;
      endcase
    end
  end

  // ---------------- operand registers ----------------
  // frozen while busy so the pipeline never sees a torn operand set
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      firstOp_r <= mac_pkg::WORD_RST;
      secondOp_r <= mac_pkg::WORD_RST;
      accOp_r <= mac_pkg::WORD_RST;
      ctrl_r <= mac_pkg::CTRL_RST;
    end else if (wrEn && idle) begin
      case (avsAddress)
        mac_pkg::OFS_FIRST: firstOp_r <= (firstOp_r & ~byteMask) | wrMerged;
        mac_pkg::OFS_SECOND: secondOp_r <= (secondOp_r & ~byteMask) | wrMerged;
        mac_pkg::OFS_ACC: accOp_r <= (accOp_r & ~byteMask) | wrMerged;
        mac_pkg::OFS_CTRL: begin
          if (avsByteEnable[0] && ctrlWr.op <= mac_pkg::OP_LAST) begin
            ctrl_r <= ctrlWr;
          end
        end
        default: ctrl_r <= ctrl_r;
      endcase
    end
  end

  assign launch = wrEn && idle && (avsAddress == mac_pkg::OFS_CTRL) && avsByteEnable[0]
                  && avsWriteData[mac_pkg::CTRL_GO_BIT]
                  && (ctrlWr.op <= mac_pkg::OP_LAST);

  // ---------------- pipeline sequencing ----------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      stage_r <= mac_pkg::ST_IDLE;
    end else begin
      case (stage_r)
        mac_pkg::ST_IDLE: if (launch) stage_r <= mac_pkg::ST_MUL;
        mac_pkg::ST_MUL: stage_r <= mac_pkg::ST_ACC;
        mac_pkg::ST_ACC: stage_r <= mac_pkg::ST_IDLE;
        default: stage_r <= mac_pkg::ST_IDLE;
      endcase
    end
  end
  assign finish = (stage_r == mac_pkg::ST_ACC);

  // ---------------- multiply stage ----------------
  assign dualOp = (ctrl_r.op == mac_pkg::OP_DUAL_ACC) || (ctrl_r.op == mac_pkg::OP_LONG_DUAL_ACC);
  assign wordAccOp = (ctrl_r.op == mac_pkg::OP_HALF_ACC)
                     || (ctrl_r.op == mac_pkg::OP_WORD_HALF_ACC);

  // lane 0: selected halves, or bottom of first against straight/crossed second
  mac_half_mul lane0 (
    .firstWord(firstOp_r),
    .secondWord(secondOp_r),
    .firstTop(dualOp ? 1'b0 : ctrl_r.selFirstTop),
    .secondTop(dualOp ? ctrl_r.exchange : ctrl_r.selSecondTop),
    .product(halfProd0)
  );

  // lane 1 only matters for dual forms: top of first
  mac_half_mul lane1 (
    .firstWord(firstOp_r),
    .secondWord(secondOp_r),
    .firstTop(1'b1),
    .secondTop(!ctrl_r.exchange),
    .product(halfProd1)
  );

  always_comb begin
    whHalf = halfPick(secondOp_r, ctrl_r.selSecondTop);
    whProd = $signed(firstOp_r) * whHalf;
    signedLong = $signed(firstOp_r) * $signed(secondOp_r);
    prod_nxt = mac_pkg::LONG_RST;
    addend_nxt = mac_pkg::LONG_RST;
    case (ctrl_r.op)
      mac_pkg::OP_UL_MUL: begin
        prod_nxt = {{mac_pkg::WORD_W{1'b0}}, firstOp_r} * {{mac_pkg::WORD_W{1'b0}}, secondOp_r};
      end
      mac_pkg::OP_UL_MUL_ADD_ADD: begin
        prod_nxt = {{mac_pkg::WORD_W{1'b0}}, firstOp_r} * {{mac_pkg::WORD_W{1'b0}}, secondOp_r};
        addend_nxt = {{mac_pkg::WORD_W{1'b0}}, destHi_r} + {{mac_pkg::WORD_W{1'b0}}, destLo_r};
      end
      mac_pkg::OP_UL_MUL_ACC: begin
        prod_nxt = {{mac_pkg::WORD_W{1'b0}}, firstOp_r} * {{mac_pkg::WORD_W{1'b0}}, secondOp_r};
        addend_nxt = {destHi_r, destLo_r};
      end
      mac_pkg::OP_HALF_ACC: begin
        prod_nxt = sext32(halfProd0);
        addend_nxt = sext32(accOp_r);
      end
      mac_pkg::OP_WORD_HALF_ACC: begin
        prod_nxt = sext32(whProd[mac_pkg::WH_SHIFT +: mac_pkg::WORD_W]);
        addend_nxt = sext32(accOp_r);
      end
      mac_pkg::OP_DUAL_ACC: begin
        prod_nxt = sext32(halfProd0) + sext32(halfProd1);
        addend_nxt = sext32(accOp_r);
      end
      mac_pkg::OP_LONG_ACC: begin
        prod_nxt = signedLong;
        addend_nxt = {destHi_r, destLo_r};
      end
      mac_pkg::OP_LONG_HALF_ACC: begin
        prod_nxt = sext32(halfProd0);
        addend_nxt = {destHi_r, destLo_r};
      end
      mac_pkg::OP_LONG_DUAL_ACC: begin
        prod_nxt = sext32(halfProd0) + sext32(halfProd1);
        addend_nxt = {destHi_r, destLo_r};
      end
      default: prod_nxt = mac_pkg::LONG_RST;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      prod_r <= mac_pkg::LONG_RST;
      addend_r <= mac_pkg::LONG_RST;
    end else if (stage_r == mac_pkg::ST_MUL) begin
      prod_r <= prod_nxt;
      addend_r <= addend_nxt;
    end
  end

  // ---------------- accumulate stage ----------------
  assign sum = prod_r + addend_r;
  // the product alone never overflows, so only the 32-bit add is watched
  assign satOvf = finish && wordAccOp
                  && (prod_r[mac_pkg::WORD_W-1] == addend_r[mac_pkg::WORD_W-1])
                  && (sum[mac_pkg::WORD_W-1] != prod_r[mac_pkg::WORD_W-1]);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      destLo_r <= mac_pkg::WORD_RST;
      destHi_r <= mac_pkg::WORD_RST;
      result_r <= mac_pkg::WORD_RST;
    end else if (finish) begin
      if (wordAccOp || ctrl_r.op == mac_pkg::OP_DUAL_ACC) begin
        result_r <= sum[0 +: mac_pkg::WORD_W];
      end else begin
        destLo_r <= sum[0 +: mac_pkg::WORD_W];
        destHi_r <= sum[mac_pkg::WORD_W +: mac_pkg::WORD_W];
      end
    end else if (wrEn && idle && avsAddress == mac_pkg::OFS_DEST_LO) begin
      destLo_r <= (destLo_r & ~byteMask) | wrMerged;
    end else if (wrEn && idle && avsAddress == mac_pkg::OFS_DEST_HI) begin
      destHi_r <= (destHi_r & ~byteMask) | wrMerged;
    end
  end

  // ---------------- status flags and interrupt ----------------
  // condition flags change only by software; saturation set wins over clear
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      flags_r <= mac_pkg::FLAGS_RST;
    end else begin
      if (wrEn && avsAddress == mac_pkg::OFS_FLAGS) begin
        flags_r <= (flags_r & ~byteMask[mac_pkg::FLAGS_LSB +: mac_pkg::FLAGS_W])
                   | wrMerged[mac_pkg::FLAGS_LSB +: mac_pkg::FLAGS_W];
      end
      if (satOvf) begin
        flags_r[mac_pkg::FLAG_Q] <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      irqStat_r <= mac_pkg::IRQ_RST;
      irqMask_r <= mac_pkg::IRQ_RST;
    end else begin
      irqStat_r <= (irqStat_r & ~((wrEn && avsAddress == mac_pkg::OFS_IRQ_STAT)
                                  ? wrMerged[mac_pkg::IRQ_W-1:0] : mac_pkg::IRQ_RST))
                   | ({mac_pkg::IRQ_W{1'b0}} | (mac_pkg::IRQ_W'(finish) << mac_pkg::IRQ_DONE)
                   | (mac_pkg::IRQ_W'(satOvf) << mac_pkg::IRQ_SAT));
      if (wrEn && avsAddress == mac_pkg::OFS_IRQ_MASK) begin
        irqMask_r <= (irqMask_r & ~byteMask[mac_pkg::IRQ_W-1:0]) | wrMerged[mac_pkg::IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(irqStat_r & irqMask_r);
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  sequence runSeq;
    stage_r == mac_pkg::ST_MUL ##1 stage_r == mac_pkg::ST_ACC ##1 stage_r == mac_pkg::ST_IDLE;
  endsequence

  sequence finishOp(mac_pkg::mac_op_t o);
    finish && ctrl_r.op == o;
  endsequence

  ul_mul_result_a: assert property (finishOp(mac_pkg::OP_UL_MUL) |=>
    {destHi_r, destLo_r} == {{mac_pkg::WORD_W{1'b0}}, firstOp_r} * {{mac_pkg::WORD_W{1'b0}}, secondOp_r})
    else $error("unsigned long product wrong");
  ul_add_add_a: assert property (finishOp(mac_pkg::OP_UL_MUL_ADD_ADD) |=>
    {destHi_r, destLo_r} == {{mac_pkg::WORD_W{1'b0}}, firstOp_r} * {{mac_pkg::WORD_W{1'b0}}, secondOp_r}
      + {{mac_pkg::WORD_W{1'b0}}, $past(destHi_r)} + {{mac_pkg::WORD_W{1'b0}}, $past(destLo_r)})
    else $error("multiply-add-add result wrong");
  ul_acc_pair_a: assert property (finishOp(mac_pkg::OP_UL_MUL_ACC) |=>
    {destHi_r, destLo_r} == {{mac_pkg::WORD_W{1'b0}}, firstOp_r} * {{mac_pkg::WORD_W{1'b0}}, secondOp_r}
      + {$past(destHi_r), $past(destLo_r)})
    else $error("unsigned accumulate result wrong");
  long_signed_a: assert property (finishOp(mac_pkg::OP_LONG_ACC) |=>
    {destHi_r, destLo_r} == signedLong + {$past(destHi_r), $past(destLo_r)})
    else $error("signed long accumulate wrong");
  half_acc_a: assert property (finishOp(mac_pkg::OP_HALF_ACC) |=>
    result_r == mac_pkg::WORD_W'($signed(halfPick(firstOp_r, ctrl_r.selFirstTop))
      * $signed(halfPick(secondOp_r, ctrl_r.selSecondTop))) + accOp_r)
    else $error("halfword accumulate wrong");
  long_half_a: assert property (finishOp(mac_pkg::OP_LONG_HALF_ACC) |=>
    {destHi_r, destLo_r} == sext32(mac_pkg::WORD_W'($signed(halfPick(firstOp_r, ctrl_r.selFirstTop))
      * $signed(halfPick(secondOp_r, ctrl_r.selSecondTop)))) + {$past(destHi_r), $past(destLo_r)})
    else $error("long halfword accumulate wrong");
  sat_set_a: assert property (satOvf |=>
    flags_r[mac_pkg::FLAG_Q] && irqStat_r[mac_pkg::IRQ_SAT])
    else $error("saturation flag not set");
  nzcv_hold_a: assert property (!(wrEn && avsAddress == mac_pkg::OFS_FLAGS) |=>
    $stable(flags_r[mac_pkg::FLAGS_W-1:mac_pkg::NZCV_LSB]))
    else $error("condition flags changed by the unit");
  dual_flags_a: assert property (finish && dualOp
    && !(wrEn && avsAddress == mac_pkg::OFS_FLAGS) |=> $stable(flags_r))
    else $error("dual form changed a flag");
  launch_run_a: assert property (launch |=> runSeq)
    else $error("pipeline did not finish in three cycles");
endmodule

// *** tb.sv ***
// self-checking bench for the multiply-accumulate unit
`timescale 1ns/1ps
module tb;
  logic sys_clk;
  logic resetn;
  logic [mac_pkg::ADDR_W-1:0] avsAddress;
  logic avsRead;
  logic avsWrite;
  logic [mac_pkg::DATA_W-1:0] avsWriteData;
  logic [mac_pkg::BE_W-1:0] avsByteEnable;
  logic [mac_pkg::DATA_W-1:0] avsReadData;
  logic avsWaitRequest;
  logic irq;
  int num_errors = 0;
  int total_checks = 0;

  mac_unit i_mac_unit (.sys_clk(sys_clk), .resetn(resetn), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
    .avsByteEnable(avsByteEnable), .avsReadData(avsReadData),
    .avsWaitRequest(avsWaitRequest), .irq(irq));
  mac_host_model host (.sys_clk(sys_clk), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable),
    .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest));

  initial begin
    sys_clk = 1'h0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic bus(input logic w, input logic [mac_pkg::ADDR_W-1:0] a,
      input logic [31:0] d, output logic [31:0] q);
    bit ok;
    host.xfer(w, a, d, q, ok);
    if (!ok) begin
      num_errors++;
      wrap_up();
    end
  endtask

  // {saturation, 64-bit result}; 32-bit forms use the low word
  function automatic logic [64:0] ref_mac(input logic [6:0] c, input logic [31:0] a,
      input logic [31:0] b, input logic [31:0] acc, input logic [63:0] pair);
    longint ha, hb, at, ab, bt, bb, s;
    ha = longint'(signed'(c[4] ? a[31:16] : a[15:0]));
    hb = longint'(signed'(c[5] ? b[31:16] : b[15:0]));
    at = longint'(signed'(a[31:16]));
    ab = longint'(signed'(a[15:0]));
    bt = longint'(signed'(c[6] ? b[15:0] : b[31:16]));
    bb = longint'(signed'(c[6] ? b[31:16] : b[15:0]));
    case (c[3:0])
      4'h0: s = longint'({32'h0, a} * {32'h0, b});
      4'h1: s = longint'({32'h0, a} * {32'h0, b} + pair[63:32] + pair[31:0]);
      4'h2: s = longint'({32'h0, a} * {32'h0, b} + pair);
      4'h3: s = ha * hb + longint'(signed'(acc));
      4'h4: s = ((longint'(signed'(a)) * hb) >>> 16) + longint'(signed'(acc));
      4'h5: s = at * bt + ab * bb + longint'(signed'(acc));
      4'h6: s = longint'(signed'(a)) * longint'(signed'(b)) + longint'(pair);
      4'h7: s = ha * hb + longint'(pair);
      default: s = at * bt + ab * bb + longint'(pair);
    endcase
    return {(c[3:0] == 4'h3 || c[3:0] == 4'h4) && s != longint'(signed'(s[31:0])), s};
  endfunction

  task automatic run_op(input logic [6:0] c, input logic [31:0] a, input logic [31:0] b,
      input logic [31:0] acc, input logic [63:0] pair);
    logic [64:0] e;
    logic [31:0] v[5];
    logic [31:0] r;
    logic [31:0] hi;
    int n;
    e = ref_mac(c, a, b, acc, pair);
    v = '{a, b, acc, pair[31:0], pair[63:32]};
    // condition flags preset so that any disturbance shows
    bus(1'h1, mac_pkg::OFS_FLAGS, 32'hA000_0000, r);
    bus(1'h1, mac_pkg::OFS_IRQ_STAT, 32'h0000_0003, r);
    for (n = 0; n < 5; n++) begin
      bus(1'h1, mac_pkg::OFS_FIRST + 6'(4 * n), v[n], r);
    end
    bus(1'h1, mac_pkg::OFS_CTRL, {24'h00_0000, 1'h1, c}, r);
    r = 32'h0000_0001;
    for (n = 0; n < 20 && r[0] !== 1'h0; n++) begin
      bus(1'h0, mac_pkg::OFS_STATUS, 32'h0, r);
    end
    check("busy", {63'h0, r[0]}, 64'h0);
    if (r[0] !== 1'h0) begin
      wrap_up();
    end
    if (c[3:0] inside {4'h3, 4'h4, 4'h5}) begin
      bus(1'h0, mac_pkg::OFS_RESULT, 32'h0, r);
      check("result", {32'h0, r}, {32'h0, e[31:0]});
    end else begin
      bus(1'h0, mac_pkg::OFS_DEST_LO, 32'h0, r);
      bus(1'h0, mac_pkg::OFS_DEST_HI, 32'h0, hi);
      check("pair", {hi, r}, e[63:0]);
    end
    bus(1'h0, mac_pkg::OFS_FLAGS, 32'h0, r);
    check("flags", {59'h0, r[31:27]}, {59'h0, 4'hA, e[64]});
    bus(1'h0, mac_pkg::OFS_IRQ_STAT, 32'h0, r);
    check("irq status", {62'h0, r[1:0]}, {62'h0, e[64], 1'h1});
  endtask

  task automatic test_unsigned();
    run_op(7'h00, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0, 64'h0000_5678_0000_1234);
    run_op(7'h01, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0, 64'hFFFF_FFFF_FFFF_FFFF);
    run_op(7'h02, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0, 64'h0000_0002_FFFF_FFFF);
    $display("test unsigned done");
  endtask

  task automatic test_half();
    for (int i = 0; i < 4; i++) begin
      run_op({1'h0, 2'(i), 4'h3}, 32'h0003_FFFE, 32'h7FFF_0005, 32'h0000_0100, 64'h0);
    end
    run_op(7'h03, 32'h1234_8000, 32'h5678_8000, 32'h4000_0000, 64'h0);
    run_op(7'h04, 32'h8000_0001, 32'h1234_FFFF, 32'h0000_0010, 64'h0);
    run_op(7'h24, 32'h8000_0001, 32'h1234_FFFF, 32'h0000_0010, 64'h0);
    run_op(7'h04, 32'h7FFF_FFFF, 32'h0000_7FFF, 32'h7FFF_0000, 64'h0);
    run_op(7'h05, 32'h8000_7FFF, 32'h8000_0003, 32'h7FFF_FFF0, 64'h0);
    run_op(7'h45, 32'h8000_7FFF, 32'h0003_8000, 32'h0000_0007, 64'h0);
    $display("test halfword done");
  endtask

  task automatic test_long();
    run_op(7'h06, 32'h8000_0000, 32'h7FFF_FFFF, 32'h0, 64'hFFFF_FFFF_0000_0001);
    run_op(7'h17, 32'h8000_1234, 32'h5555_0002, 32'h0, 64'h0000_0000_FFFF_FFFF);
    run_op(7'h27, 32'h8000_1234, 32'h5555_0002, 32'h0, 64'h0000_0000_FFFF_FFFF);
    run_op(7'h08, 32'h8000_8000, 32'h8000_8000, 32'h0, 64'h7FFF_FFFF_FFFF_FFFF);
    run_op(7'h48, 32'h0002_FFFF, 32'h0003_0004, 32'h0, 64'h0);
    $display("test long done");
  endtask

  task automatic test_irq_bus();
    logic [31:0] r;
    logic [31:0] keep;
    check("irq idle", {63'h0, irq}, 64'h0);
    bus(1'h1, mac_pkg::OFS_IRQ_MASK, 32'h0000_0001, r);
    run_op(7'h00, 32'h0000_0003, 32'h0000_0005, 32'h0, 64'h0);
    check("irq raised", {63'h0, irq}, 64'h1);
    bus(1'h1, mac_pkg::OFS_IRQ_STAT, 32'h0000_0001, r);
    repeat (3) @(posedge sys_clk);
    check("irq cleared", {63'h0, irq}, 64'h0);
    bus(1'h1, mac_pkg::OFS_IRQ_MASK, 32'h0, r);
    run_op(7'h03, 32'h0000_0002, 32'h0000_0003, 32'h0, 64'h0);
    check("irq masked", {63'h0, irq}, 64'h0);
    // result is read-only and holes read as zero
    bus(1'h0, mac_pkg::OFS_RESULT, 32'h0, keep);
    bus(1'h1, mac_pkg::OFS_RESULT, ~keep, r);
    bus(1'h0, mac_pkg::OFS_RESULT, 32'h0, r);
    check("result ro", {32'h0, r}, {32'h0, keep});
    bus(1'h0, 6'h3C, 32'h0, r);
    check("unmapped", {32'h0, r}, 64'h0);
    // an op code past the last is dropped: no run starts, control keeps its value
    bus(1'h1, mac_pkg::OFS_CTRL, 32'h0000_008F, r);
    bus(1'h0, mac_pkg::OFS_STATUS, 32'h0, r);
    check("bad op busy", {63'h0, r[0]}, 64'h0);
    bus(1'h0, mac_pkg::OFS_CTRL, 32'h0, r);
    check("bad op ctrl", {32'h0, r}, 64'h0000_0000_0000_0003);
    $display("test irq and bus done");
  endtask

  initial begin
    resetn = 1'h0;
    repeat (16) @(posedge sys_clk);
    resetn <= 1'h1;
    test_irq_bus();
    test_unsigned();
    test_half();
    test_long();
    wrap_up();
  end
endmodule
